// ---- design/upgrade_pkg.sv ----
// constants and types shared by the remote upgrade serial access block
// assumes a single 50 MHz system clock and asynchronous active-low reset
package upgrade_pkg;

  // ****************************************************************
  // field widths
  // ****************************************************************
  localparam int unsigned STATUS_W = 5;
  localparam int unsigned CTRL_W = 22;
  localparam int unsigned SHIFT_W = STATUS_W + CTRL_W;

  // ****************************************************************
  // status bit positions
  // ****************************************************************
  localparam int unsigned CRC_CAUSE_BIT = 0;
  localparam int unsigned ERROR_PIN_CAUSE_BIT = 1;
  localparam int unsigned FABRIC_CAUSE_BIT = 2;
  localparam int unsigned EXT_PIN_CAUSE_BIT = 3;
  localparam int unsigned WATCHDOG_CAUSE_BIT = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [STATUS_W-1:0] STATUS_RST = 5'h00;
  localparam logic [CTRL_W-1:0] CTRL_RST = 22'h000000;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 27'h0000000;

  // ****************************************************************
  // image selection codes
  // ****************************************************************
  typedef enum logic {
    load_factory,
    load_application
  } load_target_e;

endpackage : upgrade_pkg

// ---- design/upgrade_link_if.sv ----
// bundle of synchronised pin events between the edge finder and the core
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface upgrade_link_if;
  logic shift_edge;
  logic shift_sel;
  logic capture_sel;
  logic serial_bit;
  logic restart_fall;
  logic request_low;
  logic request_rise;

  modport source (output shift_edge, shift_sel, capture_sel, serial_bit,
    restart_fall, request_low, request_rise);
  modport sink (input shift_edge, shift_sel, capture_sel, serial_bit,
    restart_fall, request_low, request_rise);
endinterface : upgrade_link_if

// ---- design/upgrade_pin_sync.sv ----
// double-flop synchronisers and edge detection for the user-logic pins
// assumes every pin is asynchronous to clock
`timescale 1ns/1ps
module upgrade_pin_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic upgrade_shift_clock,
  input wire logic shift_or_load_select,
  input wire logic capture_or_commit_select,
  input wire logic upgrade_serial_in,
  input wire logic watchdog_restart_n,
  input wire logic reconfig_request_n,
  upgrade_link_if.source link
);
  // ****************************************************************
  // two-stage synchronisers
  // ****************************************************************
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic [5:0] prev_q;
  logic [5:0] raw;

  assign raw = {reconfig_request_n, watchdog_restart_n, upgrade_serial_in,
    capture_or_commit_select, shift_or_load_select, upgrade_shift_clock};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 6'h30;
      sync_q <= 6'h30;
      prev_q <= 6'h30;
    end else begin
      meta_q <= raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // ****************************************************************
  // edges, data sampled with the pre-edge settled values
  // ****************************************************************
  assign link.shift_edge = sync_q[0] && !prev_q[0];
  assign link.shift_sel = prev_q[1];
  assign link.capture_sel = prev_q[2];
  assign link.serial_bit = prev_q[3];
  assign link.restart_fall = !sync_q[4] && prev_q[4];
  assign link.request_low = !sync_q[5] && prev_q[5];
  assign link.request_rise = sync_q[5] && !prev_q[5];
endmodule : upgrade_pin_sync

// ---- design/upgrade_boot_ctrl.sv ----
// decides which image a reconfiguration request loads
// assumes one-cycle request pulse and settled mode inputs
`timescale 1ns/1ps
module upgrade_boot_ctrl (
  input wire logic clock,
  input wire logic rstn,
  input wire logic request,
  input wire logic remote_mode,
  input wire logic factory_image,
  output logic start_q,
  output upgrade_pkg::load_target_e target_q
);
  import upgrade_pkg::*;

  // ****************************************************************
  // target selection
  // ****************************************************************
  load_target_e target_d;

  assign target_d = (!remote_mode) ? load_application :
    (factory_image ? load_application : load_factory);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
      target_q <= load_factory;
    end else begin
      start_q <= request;
      if (request) begin
        target_q <= target_d;
      end
    end
  end
endmodule : upgrade_boot_ctrl

// ---- design/remote_upgrade_serial_access.sv ----
// top of the serial access port between upgrade circuitry and user logic
// assumes user pins asynchronous to clock; mode and image are level inputs
`timescale 1ns/1ps
module remote_upgrade_serial_access (
  input wire logic clock,
  input wire logic rstn,
  input wire logic upgrade_shift_clock,
  input wire logic shift_or_load_select,
  input wire logic capture_or_commit_select,
  input wire logic upgrade_serial_in,
  input wire logic watchdog_restart_n,
  input wire logic reconfig_request_n,
  input wire logic remote_mode,
  input wire logic factory_image,
  input wire logic [upgrade_pkg::STATUS_W-1:0] cause_events,
  output logic upgrade_serial_out,
  output logic watchdog_reload,
  output logic reconfig_start,
  output logic load_application_image,
  output logic [upgrade_pkg::CTRL_W-1:0] control_word,
  output logic [upgrade_pkg::STATUS_W-1:0] status_word
);
  import upgrade_pkg::*;

  // ****************************************************************
  // pin synchronisation, six user signals in total
  // ****************************************************************
  upgrade_link_if link ();

  upgrade_pin_sync u_sync (
    .clock(clock),
    .rstn(rstn),
    .upgrade_shift_clock(upgrade_shift_clock),
    .shift_or_load_select(shift_or_load_select),
    .capture_or_commit_select(capture_or_commit_select),
    .upgrade_serial_in(upgrade_serial_in),
    .watchdog_restart_n(watchdog_restart_n),
    .reconfig_request_n(reconfig_request_n),
    .link(link)
  );

  // ****************************************************************
  // mode inputs synchronised
  // ****************************************************************
  logic [1:0] mode_meta_q;
  logic [1:0] mode_q;
  logic remote_q;
  logic factory_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_meta_q <= 2'h0;
      mode_q <= 2'h0;
    end else begin
      mode_meta_q <= {remote_mode, factory_image};
      mode_q <= mode_meta_q;
    end
  end

  assign remote_q = mode_q[1];
  assign factory_q = mode_q[0];

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [SHIFT_W-1:0] shift_q;
  logic [SHIFT_W-1:0] shift_d;
  logic [CTRL_W-1:0] update_q;
  logic [CTRL_W-1:0] control_q;
  logic [STATUS_W-1:0] status_q;
  logic [STATUS_W-1:0] cause_meta_q;
  logic [STATUS_W-1:0] cause_q;
  logic serial_out_q;
  logic reload_q;

  // ****************************************************************
  // operation decode
  // ****************************************************************
  logic do_shift;
  logic do_capture;
  logic do_commit;
  logic [CTRL_W-1:0] readback;

  assign do_shift = link.shift_edge && link.shift_sel;
  assign do_capture = link.shift_edge && !link.shift_sel && link.capture_sel;
  assign do_commit = link.shift_edge && !link.shift_sel && !link.capture_sel
    && remote_q && factory_q;
  assign readback = factory_q ? update_q : control_q;

  always_comb begin
    shift_d = shift_q;
    if (do_shift) begin
      shift_d = {shift_q[SHIFT_W-2:0], link.serial_bit};
    end else if (do_capture) begin
      shift_d = {status_q, readback};
    end
  end

  // ****************************************************************
  // shift register and serial out
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shift_q <= SHIFT_RST;
      serial_out_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      serial_out_q <= shift_d[SHIFT_W-1];
    end
  end

  // ****************************************************************
  // update register
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      update_q <= CTRL_RST;
    end else if (do_commit) begin
      update_q <= shift_q[CTRL_W-1:0];
    end
  end

  // ****************************************************************
  // control register
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      control_q <= CTRL_RST;
    end else if (link.request_rise) begin
      control_q <= update_q;
    end
  end

  // ****************************************************************
  // status register, sticky causes
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cause_meta_q <= STATUS_RST;
      cause_q <= STATUS_RST;
      status_q <= STATUS_RST;
    end else begin
      cause_meta_q <= cause_events;
      cause_q <= cause_meta_q;
      status_q <= status_q | cause_q
        | {{(STATUS_W-FABRIC_CAUSE_BIT-1){1'b0}}, link.request_low,
           {FABRIC_CAUSE_BIT{1'b0}}};
    end
  end

  // ****************************************************************
  // watchdog restart
  // ****************************************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reload_q <= 1'b0;
    end else begin
      reload_q <= link.restart_fall && remote_q && !factory_q;
    end
  end

  // ****************************************************************
  // reconfiguration decision
  // ****************************************************************
  load_target_e target;
  logic start;

  upgrade_boot_ctrl u_boot (
    .clock(clock),
    .rstn(rstn),
    .request(link.request_low),
    .remote_mode(remote_q),
    .factory_image(factory_q),
    .start_q(start),
    .target_q(target)
  );

  // ****************************************************************
  // outputs from flip-flops
  // ****************************************************************
  assign upgrade_serial_out = serial_out_q;
  assign watchdog_reload = reload_q;
  assign reconfig_start = start;
  assign load_application_image = logic'(target);
  assign control_word = control_q;
  assign status_word = status_q;
endmodule : remote_upgrade_serial_access

// ---- tb/upgrade_assertions.sv ----
// port assertions for the serial access top
// assumes bind onto remote_upgrade_serial_access
`timescale 1ns/1ps
module upgrade_assertions (
  input wire logic clock,
  input wire logic rstn,
  input wire logic upgrade_shift_clock,
  input wire logic shift_or_load_select,
  input wire logic capture_or_commit_select,
  input wire logic upgrade_serial_in,
  input wire logic watchdog_restart_n,
  input wire logic reconfig_request_n,
  input wire logic remote_mode,
  input wire logic factory_image,
  input wire logic [upgrade_pkg::STATUS_W-1:0] cause_events,
  input wire logic upgrade_serial_out,
  input wire logic watchdog_reload,
  input wire logic reconfig_start,
  input wire logic load_application_image,
  input wire logic [upgrade_pkg::CTRL_W-1:0] control_word,
  input wire logic [upgrade_pkg::STATUS_W-1:0] status_word
);
  import upgrade_pkg::*;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  AST_START_FALL: assert property ($fell(reconfig_request_n) |-> ##[2:6] reconfig_start)
    else $error("no start after request");
  AST_START_PULSE: assert property (reconfig_start |=> !reconfig_start)
    else $error("start longer than one cycle");
  AST_RELOAD_FALL: assert property ($fell(watchdog_restart_n) && remote_mode && !factory_image
    |-> ##[2:6] watchdog_reload) else $error("no reload after restart");
  AST_RELOAD_GATE: assert property (watchdog_reload |-> remote_mode && !factory_image)
    else $error("reload outside remote application");
  AST_TARGET_LOCAL: assert property (reconfig_start && !remote_mode |=> load_application_image)
    else $error("local request not to application");
  AST_TARGET_REMOTE: assert property (reconfig_start && remote_mode
    |=> load_application_image == factory_image) else $error("remote target wrong");
  AST_CTRL_RISE: assert property (control_word != $past(control_word) |-> reconfig_request_n)
    else $error("control changed while request low");
  AST_STATUS_STICKY: assert property (($past(status_word) & ~status_word) == 5'h00)
    else $error("status bit cleared");
  AST_CAUSE_WD: assert property ($rose(cause_events[WATCHDOG_CAUSE_BIT])
    |-> ##[1:6] status_word[WATCHDOG_CAUSE_BIT]) else $error("watchdog cause not set");
  AST_FABRIC: assert property (reconfig_start |-> ##[0:1] status_word[FABRIC_CAUSE_BIT])
    else $error("fabric cause not set");
endmodule : upgrade_assertions

bind remote_upgrade_serial_access upgrade_assertions i_upgrade_assertions (.clock(clock),
  .rstn(rstn), .upgrade_shift_clock(upgrade_shift_clock),
  .shift_or_load_select(shift_or_load_select), .upgrade_serial_in(upgrade_serial_in),
  .capture_or_commit_select(capture_or_commit_select), .watchdog_restart_n(watchdog_restart_n),
  .reconfig_request_n(reconfig_request_n), .remote_mode(remote_mode),
  .factory_image(factory_image), .cause_events(cause_events), .control_word(control_word),
  .upgrade_serial_out(upgrade_serial_out), .watchdog_reload(watchdog_reload),
  .reconfig_start(reconfig_start), .load_application_image(load_application_image),
  .status_word(status_word));

// ---- tb/user_logic_model.sv ----
// user logic model driving six of the seven access pins
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
module user_logic_model
  import upgrade_pkg::*;
(
  input wire logic clock,
  input wire logic upgrade_serial_out,
  output logic upgrade_shift_clock,
  output logic shift_or_load_select,
  output logic capture_or_commit_select,
  output logic upgrade_serial_in,
  output logic watchdog_restart_n,
  output logic reconfig_request_n
);
  // ****************************************************************
  // pin sequences
  // ****************************************************************
  initial begin
    {upgrade_shift_clock, shift_or_load_select, capture_or_commit_select} = 3'h0;
    {upgrade_serial_in, watchdog_restart_n, reconfig_request_n} = 3'h3;
  end
  task automatic pulse(input logic sh, input logic cp, input logic d, output logic q);
    shift_or_load_select <= sh;
    capture_or_commit_select <= cp;
    upgrade_serial_in <= d;
    repeat (4) @(posedge clock);
    q = upgrade_serial_out;
    upgrade_shift_clock <= 1'b1;
    repeat (3) @(posedge clock);
    upgrade_serial_in <= ~d;
    @(posedge clock);
    upgrade_shift_clock <= 1'b0;
  endtask : pulse
  task automatic xfer(input logic cp, input logic [SHIFT_W-1:0] w, output logic [SHIFT_W-1:0] r);
    for (int i = SHIFT_W - 1; i >= 0; i--) begin
      pulse(1'b1, cp, w[i], r[i]);
    end
  endtask : xfer
  task automatic request;
    reconfig_request_n <= 1'b0;
    repeat (8) @(posedge clock);
    reconfig_request_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : request
  task automatic restart;
    watchdog_restart_n <= 1'b0;
    repeat (8) @(posedge clock);
    watchdog_restart_n <= 1'b1;
    repeat (8) @(posedge clock);
  endtask : restart
endmodule : user_logic_model

// ---- tb/testbench.sv ----
// self-checking bench for the serial access block
// assumes user_logic_model drives the user pins
`timescale 1ns/1ps
module testbench;
  import upgrade_pkg::*;
  // ****************************************************************
  // wiring
  // ****************************************************************
  logic clock, rstn, remote_mode, factory_image, upgrade_shift_clock, shift_or_load_select;
  logic capture_or_commit_select, upgrade_serial_in, watchdog_restart_n, reconfig_request_n;
  logic upgrade_serial_out, watchdog_reload, reconfig_start, load_application_image, q;
  logic [STATUS_W-1:0] cause_events, status_word;
  logic [CTRL_W-1:0] control_word;
  logic [SHIFT_W-1:0] rd;
  localparam logic [CTRL_W-1:0] U1 = 22'h2c3a5b;
  localparam logic [CTRL_W-1:0] U2 = 22'h13c5a4;
  int err_count, cmp_count, pulses, starts;
  remote_upgrade_serial_access i_remote_upgrade_serial_access (.clock(clock), .rstn(rstn),
    .upgrade_shift_clock(upgrade_shift_clock), .shift_or_load_select(shift_or_load_select),
    .capture_or_commit_select(capture_or_commit_select), .upgrade_serial_in(upgrade_serial_in),
    .watchdog_restart_n(watchdog_restart_n), .reconfig_request_n(reconfig_request_n),
    .remote_mode(remote_mode), .factory_image(factory_image), .cause_events(cause_events),
    .upgrade_serial_out(upgrade_serial_out), .watchdog_reload(watchdog_reload),
    .reconfig_start(reconfig_start), .load_application_image(load_application_image),
    .control_word(control_word), .status_word(status_word));
  user_logic_model i_user_logic_model (.clock(clock), .upgrade_serial_out(upgrade_serial_out),
    .upgrade_shift_clock(upgrade_shift_clock), .shift_or_load_select(shift_or_load_select),
    .capture_or_commit_select(capture_or_commit_select), .upgrade_serial_in(upgrade_serial_in),
    .watchdog_restart_n(watchdog_restart_n), .reconfig_request_n(reconfig_request_n));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (watchdog_reload === 1'b1) pulses++;
    if (reconfig_start === 1'b1) starts++;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  task automatic mode(input logic r, input logic f);
    remote_mode <= r;
    factory_image <= f;
    repeat (4) @(posedge clock);
  endtask : mode
  task automatic commit(input logic [CTRL_W-1:0] u);
    i_user_logic_model.xfer(1'b0, {5'h1f, u}, rd);
    i_user_logic_model.pulse(1'b0, 1'b0, 1'b0, q);
  endtask : commit
  task automatic read_back;
    i_user_logic_model.pulse(1'b0, 1'b1, 1'b0, q);
    i_user_logic_model.xfer(1'b1, 27'h0000000, rd);
  endtask : read_back
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_factory;
    mode(1'b1, 1'b1);
    commit(U1);
    check("ctrl", 22'h0, control_word);
    read_back();
    check("read", {5'h00, U1}, rd);
    i_user_logic_model.request();
    check("starts", 1, starts);
    check("target", 1'b1, load_application_image);
    check("ctrl", U1, control_word);
    check("status", 5'h04, status_word);
  endtask : t_factory
  task automatic t_app;
    mode(1'b1, 1'b0);
    i_user_logic_model.restart();
    check("reloads", 1, pulses);
    commit(U2);
    read_back();
    check("read", {5'h04, U1}, rd);
    i_user_logic_model.request();
    check("target", 1'b0, load_application_image);
  endtask : t_app
  task automatic t_local;
    mode(1'b0, 1'b1);
    i_user_logic_model.restart();
    check("reloads", 1, pulses);
    commit(U2);
    read_back();
    check("read", {5'h04, U1}, rd);
    i_user_logic_model.request();
    check("target", 1'b1, load_application_image);
    check("ctrl", U1, control_word);
  endtask : t_local
  task automatic t_causes;
    logic [STATUS_W-1:0] e;
    e = 5'h04;
    for (int i = 0; i < STATUS_W; i++) begin
      cause_events <= 5'h01 << i;
      repeat (6) @(posedge clock);
      cause_events <= 5'h00;
      repeat (2) @(posedge clock);
      e[i] = 1'b1;
      check("status", e, status_word);
    end
    read_back();
    check("read", 5'h1f, rd[SHIFT_W-1:CTRL_W]);
  endtask : t_causes
  initial begin
    rstn = 1'b0;
    remote_mode = 1'b1;
    factory_image = 1'b1;
    cause_events = 5'h00;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    repeat (4) @(posedge clock);
    check("idle", 5'h00, {status_word[0], reconfig_start, watchdog_reload, control_word[0]});
    t_factory();
    t_app();
    t_local();
    t_causes();
    test_done();
  end
  initial begin
    #1ms;
    err_count++;
    test_done();
  end
endmodule : testbench
